// *** common/nvm_pkg.sv ***
package nvm_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_KHZ       = 100000;
    localparam int PWRT_MS       = 64;
    localparam int PWRT_CYCLES   = PWRT_MS * CLK_KHZ;
    // cell write time is not fixed by the interface; plain default
    localparam int WRITE_TIME_US = 4000;
    localparam int WRITE_CYCLES  = (WRITE_TIME_US * CLK_KHZ) / 1000;

    // ************************************************************
    // bus and memory geometry
    // ************************************************************
    localparam int WB_AW      = 8;
    localparam int WB_DW      = 32;
    localparam int REG_W      = 8;
    localparam int DATA_AW    = 8;
    localparam int DATA_DEPTH = 256;
    localparam int PROG_AW    = 12;
    localparam int PROG_DW    = 14;
    localparam int ADDR_HI_W  = PROG_AW - DATA_AW;
    localparam int DATA_HI_W  = PROG_DW - REG_W;
    localparam int RST_SRC_N  = 3;

    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [WB_AW-1:0] OFS_DATA_LOW  = 8'h00;
    localparam logic [WB_AW-1:0] OFS_ADDR_LOW  = 8'h04;
    localparam logic [WB_AW-1:0] OFS_DATA_HIGH = 8'h08;
    localparam logic [WB_AW-1:0] OFS_ADDR_HIGH = 8'h0c;
    localparam logic [WB_AW-1:0] OFS_CONTROL   = 8'h10;
    localparam logic [WB_AW-1:0] OFS_UNLOCK    = 8'h14;
    localparam logic [WB_AW-1:0] OFS_STATUS    = 8'h18;

    // ************************************************************
    // control and status fields
    // ************************************************************
    localparam int BIT_SPACE_SEL = 7;
    localparam int BIT_ABORT     = 3;
    localparam int BIT_WRITE_ENABLE_GATE      = 2;
    localparam int BIT_WR        = 1;
    localparam int BIT_RD        = 0;
    localparam int BIT_DONE      = 0;
    localparam int RST_EXT       = 0;
    localparam int RST_WDT       = 1;
    localparam int RST_BOR       = 2;

    localparam logic [REG_W-1:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [REG_W-1:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [REG_W-1:0] ERASED_BYTE = 8'hff;
    localparam logic [REG_W-1:0] BYTE_ZERO   = 8'h00;

    typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_KEY2} unlock_state_t;
    typedef enum logic [1:0] {RD_IDLE, RD_DATA, RD_SKIP, RD_FETCH} rd_state_t;

endpackage

// *** src/nvm_data_array.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvm_data_array #(
    parameter int AW    = nvm_pkg::DATA_AW,
    parameter int DEPTH = nvm_pkg::DATA_DEPTH
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_start,
    input  wire logic                      i_commit,
    input  wire logic [AW-1:0]             i_addr,
    input  wire logic [nvm_pkg::REG_W-1:0] i_data,
    input  wire logic [AW-1:0]             i_rd_addr,
    output logic      [nvm_pkg::REG_W-1:0] o_rd_data
);
    import nvm_pkg::*;

    logic [REG_W-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_addr_reg;
    logic [REG_W-1:0] wr_data_reg;

    // ************************************************************
    // latched write target
    // ************************************************************
    // the target is latched at start so later register writes by
    // software cannot change a write already under way
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_addr_reg <= '0;
            wr_data_reg <= BYTE_ZERO;
        end else if (i_start) begin
            wr_addr_reg <= i_addr;
            wr_data_reg <= i_data;
        end
    end

    // ************************************************************
    // cell array
    // ************************************************************
    // an aborted write leaves the location erased, as a real cell would
    always_ff @(posedge i_clk) begin
        if (i_start) begin
            mem[i_addr] <= ERASED_BYTE; // [R22]
        end else if (i_commit) begin
            mem[wr_addr_reg] <= wr_data_reg; // [R22]
        end
    end

    assign o_rd_data = mem[i_rd_addr];

endmodule
`default_nettype wire

// *** src/nvm_indirect_access_ctrl.sv ***
// Function
// [R01] program read upper six bits, bits 7:6 zero
// [R02] high address bits 3:0 used, 7:4 zero
// [R03] space select one program, zero data
// [R04] reset during write sets abort flag
// [R05] data writes only while write gate set
// [R06] write trigger set-only, hardware clears at end
// [R07] write trigger under program space clears instantly
// [R08] read trigger set-only, hardware clears when done
// [R09] data byte loaded the cycle after trigger
// [R10] read result held until next read/write
// [R11] 55h, AAh, trigger sequence unlocks one write
// [R12] trigger refused while write gate is clear
// [R13] gate clear never disturbs write; hardware keeps
// [R14] write end clears trigger, sets done flag
// [R15] program fetch uses second cycle, slot stalled
// [R16] program word in low/high data next cycle
// [R17] software puts two no-ops after program read
// [R18] gate clear at power-up; timer blocks writes
// [R19] software disables interrupts during unlock sequence
// [R20] data read: load address, clear select, trigger
// [R21] program read: both addresses, select, trigger
// [R22] byte write erases location before programming
// [R23] unlock port reads as zero, stores nothing
// [R24] twelve-bit word address, fourteen-bit word
// [R25] internal counter times write, trigger held
// [R26] read attempt during write is ignored
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module nvm_indirect_access_ctrl #(
    parameter int PWRT_COUNT  = nvm_pkg::PWRT_CYCLES,
    parameter int WRITE_COUNT = nvm_pkg::WRITE_CYCLES
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_wb_cyc,
    input  wire logic                        i_wb_stb,
    input  wire logic                        i_wb_we,
    input  wire logic [nvm_pkg::WB_AW-1:0]   i_wb_adr,
    input  wire logic [nvm_pkg::WB_DW-1:0]   i_wb_dat,
    input  wire logic [3:0]                  i_wb_sel,
    output logic      [nvm_pkg::WB_DW-1:0]   o_wb_dat,
    output logic                             o_wb_ack,
    input  wire logic                        i_ext_reset,
    input  wire logic                        i_watchdog_reset,
    input  wire logic                        i_brownout_reset,
    output logic      [nvm_pkg::PROG_AW-1:0] o_prog_addr,
    output logic                             o_prog_rd,
    input  wire logic [nvm_pkg::PROG_DW-1:0] i_prog_word,
    output logic                             o_cpu_stall,
    output logic                             o_write_busy,
    output logic                             o_write_done
);
    import nvm_pkg::*;

    localparam int PCW = $clog2(PWRT_COUNT + 1);
    localparam int WCW = $clog2(WRITE_COUNT + 1);
    localparam logic [PCW-1:0] PWRT_LAST = PCW'(PWRT_COUNT - 1);
    localparam logic [WCW-1:0] WR_LAST   = WCW'(WRITE_COUNT - 1);

    logic                 ack_reg;
    logic [WB_DW-1:0]     rdata_reg;
    logic [REG_W-1:0]     rdata_next;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 wr_ctrl;
    logic [RST_SRC_N-1:0] rst_meta_reg;
    logic [RST_SRC_N-1:0] rst_sync_reg;
    logic [RST_SRC_N-1:0] rst_prev_reg;
    logic [RST_SRC_N-1:0] rst_evt;
    logic                 soft_rst;
    logic [REG_W-1:0]     data_low_reg;
    logic [DATA_HI_W-1:0] data_high_reg;
    logic [REG_W-1:0]     addr_low_reg;
    logic [ADDR_HI_W-1:0] addr_high_reg;
    logic                 space_sel_reg;
    logic                 abort_reg;
    logic                 write_enable_gate_reg;
    logic                 wr_reg;
    logic                 rd_reg;
    logic                 done_reg;
    logic                 pwrt_done_reg;
    logic [PCW-1:0]       pwrt_cnt_reg;
    logic [WCW-1:0]       wr_cnt_reg;
    logic                 wr_start;
    logic                 wr_finish;
    logic                 rd_start;
    logic [REG_W-1:0]     array_byte;
    unlock_state_t        unl_state_reg;
    rd_state_t            rd_state_reg;

    // ************************************************************
    // wishbone slave
    // ************************************************************
    // writes act on the edge where ack is high, so the master sees
    // the effect exactly when it completes the cycle
    assign bus_req  = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign bus_wr   = i_wb_cyc & i_wb_stb & i_wb_we & ack_reg & i_wb_sel[0];
    assign wr_ctrl  = bus_wr & (i_wb_adr == OFS_CONTROL);
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdata_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    always_comb begin
        rdata_next = BYTE_ZERO;
        unique case (i_wb_adr)
            OFS_DATA_LOW:  rdata_next = data_low_reg;
            OFS_ADDR_LOW:  rdata_next = addr_low_reg;
            OFS_DATA_HIGH: rdata_next = {2'h0, data_high_reg}; // [R01]
            OFS_ADDR_HIGH: rdata_next = {4'h0, addr_high_reg}; // [R02]
            OFS_CONTROL: begin
                rdata_next[BIT_SPACE_SEL] = space_sel_reg;
                rdata_next[BIT_ABORT]     = abort_reg;
                rdata_next[BIT_WRITE_ENABLE_GATE]      = write_enable_gate_reg;
                rdata_next[BIT_WR]        = wr_reg;
                rdata_next[BIT_RD]        = rd_reg;
            end
            OFS_UNLOCK:    rdata_next = BYTE_ZERO; // [R23]
            OFS_STATUS:    rdata_next[BIT_DONE] = done_reg;
            default:       rdata_next = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= '0;
        end else if (bus_req) begin
            rdata_reg <= {24'h0, rdata_next};
        end
    end

    // ************************************************************
    // reset causes from pins
    // ************************************************************
    // each cause is synchronised and acts once on its rising edge;
    // all but the bus slave, the array, the abort flag and the power-up timer see it as a synchronous soft reset; the timer restarts on a brownout only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_reg <= '0;
            rst_sync_reg <= '0;
            rst_prev_reg <= '0;
        end else begin
            rst_meta_reg <= {i_brownout_reset, i_watchdog_reset, i_ext_reset};
            rst_sync_reg <= rst_meta_reg;
            rst_prev_reg <= rst_sync_reg;
        end
    end

    assign rst_evt  = rst_sync_reg & ~rst_prev_reg;
    assign soft_rst = |rst_evt;

    // ************************************************************
    // power-up timer
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwrt_cnt_reg  <= '0;
            pwrt_done_reg <= 1'b0;
        end else if (rst_evt[RST_BOR]) begin
            pwrt_cnt_reg  <= '0;
            pwrt_done_reg <= 1'b0;
        end else if (!pwrt_done_reg) begin
            pwrt_cnt_reg  <= pwrt_cnt_reg + 1'b1;
            pwrt_done_reg <= (pwrt_cnt_reg == PWRT_LAST); // [R18]
        end
    end

    // ************************************************************
    // unlock sequence
    // ************************************************************
    // any bus write other than the expected next step drops the
    // sequence, and the trigger write consumes it whatever its result
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unl_state_reg <= UNL_IDLE;
        end else if (soft_rst) begin
            unl_state_reg <= UNL_IDLE;
        end else if (bus_wr) begin
            if (i_wb_adr != OFS_UNLOCK) begin
                unl_state_reg <= UNL_IDLE; // [R11]
            end else if (i_wb_dat[REG_W-1:0] == UNLOCK_KEY1) begin
                unl_state_reg <= UNL_KEY1; // [R11]
            end else if (unl_state_reg == UNL_KEY1 &&
                         i_wb_dat[REG_W-1:0] == UNLOCK_KEY2) begin
                unl_state_reg <= UNL_KEY2; // [R11]
            end else begin
                unl_state_reg <= UNL_IDLE; // [R11]
            end
        end
    end

    // ************************************************************
    // trigger decode
    // ************************************************************
    // select and gate are taken from the value being written, so a
    // single read-modify-write of the control byte behaves as a bit set
    assign wr_start = wr_ctrl & i_wb_dat[BIT_WR] & ~wr_reg & ~rd_reg
                    & (unl_state_reg == UNL_KEY2)           // [R11]
                    & i_wb_dat[BIT_WRITE_ENABLE_GATE]                    // [R05] [R12]
                    & ~i_wb_dat[BIT_SPACE_SEL]              // [R07]
                    & pwrt_done_reg                         // [R18]
                    & ~soft_rst;
    assign rd_start = wr_ctrl & i_wb_dat[BIT_RD] & ~rd_reg
                    & ~wr_reg                               // [R26]
                    & ~soft_rst;
    assign wr_finish = wr_reg & (wr_cnt_reg == WR_LAST) & ~soft_rst;

    // ************************************************************
    // control register
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            space_sel_reg <= 1'b0;
            write_enable_gate_reg      <= 1'b0; // [R18]
        end else if (soft_rst) begin
            space_sel_reg <= 1'b0;
            write_enable_gate_reg      <= 1'b0;
        end else if (wr_ctrl) begin
            space_sel_reg <= i_wb_dat[BIT_SPACE_SEL]; // [R03]
            write_enable_gate_reg      <= i_wb_dat[BIT_WRITE_ENABLE_GATE];      // [R13]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            abort_reg <= 1'b0;
        end else if (soft_rst && wr_reg) begin
            abort_reg <= 1'b1; // [R04]
        end else if (wr_finish) begin
            abort_reg <= 1'b0; // [R04]
        end else if (wr_ctrl) begin
            abort_reg <= i_wb_dat[BIT_ABORT];
        end
    end

    // a zero written to the trigger is ignored; only completion or a
    // reset cause ends a write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_reg <= 1'b0;
        end else if (soft_rst || wr_finish) begin
            wr_reg <= 1'b0; // [R06] [R14]
        end else if (wr_start) begin
            wr_reg <= 1'b1; // [R06]
        end
    end

    // ************************************************************
    // write timing
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_cnt_reg <= '0;
        end else if (!wr_reg || soft_rst) begin
            wr_cnt_reg <= '0;
        end else begin
            wr_cnt_reg <= wr_cnt_reg + 1'b1; // [R25]
        end
    end

    // set wins over the software clear in the same cycle; a reset cause blocks the set
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_reg <= 1'b0;
        end else if (wr_finish) begin
            done_reg <= 1'b1; // [R14]
        end else if (soft_rst) begin
            done_reg <= 1'b0;
        end else if (bus_wr && i_wb_adr == OFS_STATUS &&
                     i_wb_dat[BIT_DONE]) begin
            done_reg <= 1'b0; // [R14]
        end
    end

    // ************************************************************
    // read sequencer
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_state_reg <= RD_IDLE;
            rd_reg       <= 1'b0;
        end else if (soft_rst) begin
            rd_state_reg <= RD_IDLE;
            rd_reg       <= 1'b0;
        end else begin
            unique case (rd_state_reg)
                RD_IDLE: begin
                    if (rd_start) begin
                        rd_reg <= 1'b1; // [R08]
                        if (i_wb_dat[BIT_SPACE_SEL]) begin
                            rd_state_reg <= RD_SKIP; // [R03]
                        end else begin
                            rd_state_reg <= RD_DATA; // [R03]
                        end
                    end
                end
                RD_DATA: begin
                    rd_reg       <= 1'b0; // [R08] [R09]
                    rd_state_reg <= RD_IDLE;
                end
                RD_SKIP: begin
                    rd_state_reg <= RD_FETCH; // [R15]
                end
                RD_FETCH: begin
                    rd_reg       <= 1'b0; // [R08] [R16]
                    rd_state_reg <= RD_IDLE;
                end
            endcase
        end
    end

    // the stalled slot is the one the flash fetch occupies
    assign o_cpu_stall = (rd_state_reg == RD_FETCH); // [R15]
    assign o_prog_rd   = (rd_state_reg == RD_FETCH); // [R15]
    assign o_prog_addr = {addr_high_reg, addr_low_reg}; // [R02] [R24]

    // ************************************************************
    // data and address registers
    // ************************************************************
    // a read result overrides a bus write landing on the same edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_low_reg <= BYTE_ZERO;
        end else if (soft_rst) begin
            data_low_reg <= BYTE_ZERO;
        end else if (rd_state_reg == RD_DATA) begin
            data_low_reg <= array_byte; // [R09]
        end else if (rd_state_reg == RD_FETCH) begin
            data_low_reg <= i_prog_word[REG_W-1:0]; // [R16] [R24]
        end else if (bus_wr && i_wb_adr == OFS_DATA_LOW) begin
            data_low_reg <= i_wb_dat[REG_W-1:0]; // [R10]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_high_reg <= '0;
        end else if (soft_rst) begin
            data_high_reg <= '0;
        end else if (rd_state_reg == RD_FETCH) begin
            data_high_reg <= i_prog_word[PROG_DW-1:REG_W]; // [R01] [R16]
        end else if (bus_wr && i_wb_adr == OFS_DATA_HIGH) begin
            data_high_reg <= i_wb_dat[DATA_HI_W-1:0]; // [R10]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_low_reg  <= BYTE_ZERO;
            addr_high_reg <= '0;
        end else if (soft_rst) begin
            addr_low_reg  <= BYTE_ZERO;
            addr_high_reg <= '0;
        end else if (bus_wr && i_wb_adr == OFS_ADDR_LOW) begin
            addr_low_reg  <= i_wb_dat[REG_W-1:0];
        end else if (bus_wr && i_wb_adr == OFS_ADDR_HIGH) begin
            addr_high_reg <= i_wb_dat[ADDR_HI_W-1:0]; // [R02]
        end
    end

    // ************************************************************
    // data array
    // ************************************************************
    nvm_data_array #(
        .AW    (DATA_AW),
        .DEPTH (DATA_DEPTH)
    ) u_array (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_start   (wr_start),
        .i_commit  (wr_finish),
        .i_addr    (addr_low_reg),
        .i_data    (data_low_reg),
        .i_rd_addr (addr_low_reg),
        .o_rd_data (array_byte)
    );

    assign o_write_busy = wr_reg;
    assign o_write_done = done_reg;

endmodule
`default_nettype wire

// *** verif/nvm_ctrl_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvm_ctrl_props #(
    parameter int PWRT_COUNT  = 16,
    parameter int WRITE_COUNT = 8
) (
    input wire logic                      i_clk,
    input wire logic                      i_rst_n,
    input wire logic                      i_wb_we,
    input wire logic [nvm_pkg::WB_AW-1:0] i_wb_adr,
    input wire logic [nvm_pkg::WB_DW-1:0] i_wb_dat,
    input wire logic [3:0]                i_wb_sel,
    input wire logic [nvm_pkg::WB_DW-1:0] o_wb_dat,
    input wire logic                      o_wb_ack,
    input wire logic                      o_prog_rd,
    input wire logic                      o_cpu_stall,
    input wire logic                      o_write_busy,
    input wire logic                      o_write_done
);
    import nvm_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // cycles seen busy; an aborted write never sets the done flag
    logic [31:0] busy_cnt_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) busy_cnt_reg <= 32'h0;
        else if (o_write_busy) busy_cnt_reg <= busy_cnt_reg + 32'h1;
        else busy_cnt_reg <= 32'h0;
    end
    sequence s_ctl_wr;
        o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == OFS_CONTROL
            && !o_write_busy;
    endsequence
    sequence s_rd_of(logic [7:0] a);
        o_wb_ack && !i_wb_we && i_wb_adr == a;
    endsequence
    AST_UNLOCK_ZERO: assert property (s_rd_of(OFS_UNLOCK) |->
        o_wb_dat == 32'h0) else $error("unlock port read not zero");
    AST_DATA_HIGH_TOP: assert property (s_rd_of(OFS_DATA_HIGH) |->
        o_wb_dat[7:6] == 2'h0) else $error("data high top bits set");
    AST_ADDR_HIGH_TOP: assert property (s_rd_of(OFS_ADDR_HIGH) |->
        o_wb_dat[7:4] == 4'h0) else $error("address high top bits set");
    AST_PROG_FETCH: assert property (s_ctl_wr ##0 (i_wb_dat[7] &&
        i_wb_dat[0]) |-> ##[2:3] o_prog_rd) else $error("no program fetch");
    AST_STALL_ONE: assert property (o_prog_rd |-> o_cpu_stall
        ##1 !o_prog_rd) else $error("fetch slot not one stalled cycle");
    AST_WRITE_LEN: assert property ($fell(o_write_busy) &&
        o_write_done |-> busy_cnt_reg == WRITE_COUNT)
        else $error("write time wrong");
    AST_DONE_AT_END: assert property ($rose(o_write_done) |->
        $fell(o_write_busy)) else $error("done flag without write end");
    AST_GATE_BLOCK: assert property (s_ctl_wr ##0 (i_wb_dat[1] &&
        !i_wb_dat[2]) |=> !o_write_busy[*2])
        else $error("write started with gate clear");
    AST_PROG_NO_WR: assert property (s_ctl_wr ##0 (i_wb_dat[7] &&
        i_wb_dat[1]) |=> !o_write_busy[*2])
        else $error("write started in program space");
endmodule
bind nvm_indirect_access_ctrl nvm_ctrl_props #(.PWRT_COUNT(PWRT_COUNT),
    .WRITE_COUNT(WRITE_COUNT)) i_nvm_ctrl_props (.i_clk, .i_rst_n,
    .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack,
    .o_prog_rd, .o_cpu_stall, .o_write_busy, .o_write_done);
`default_nettype wire

// *** verif/nvm_indirect_access_ctrl_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvm_indirect_access_ctrl_bench;
    import nvm_pkg::*;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, cyc = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] dat = 32'h0, rdat, seed = 32'h570b;
    logic [3:0]  sel = 4'h1;
    logic [2:0]  rst_src = 3'h0;
    logic [13:0] prog_word = 14'h0;
    logic [11:0] paddr;
    logic        ack, prd, stall, busy, done;
    int          fail_count = 0, comparisons = 0, cycles = 0;
    // rule model of the data array: erase on start, value on commit
    logic [7:0]  model_mem [int];
    always #5 i_clk = ~i_clk;
    nvm_indirect_access_ctrl #(.PWRT_COUNT(16), .WRITE_COUNT(8))
        i_nvm_indirect_access_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_ext_reset(rst_src[0]), .i_watchdog_reset(rst_src[1]),
        .i_brownout_reset(rst_src[2]), .o_prog_addr(paddr),
        .o_prog_rd(prd), .i_prog_word(prog_word), .o_cpu_stall(stall),
        .o_write_busy(busy), .o_write_done(done));
    function automatic logic [13:0] pw(logic [11:0] a);
        return {a[11:10], a} ^ 14'h15a5;
    endfunction
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // program flash model answers from the address register
    always @(posedge i_clk) prog_word <= pw(paddr);
    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            conclude();
        end
    end
    task conclude();
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
             output logic [31:0] q);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        // ack ends this wait; only the global cycle ceiling bounds it
        do @(posedge i_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        @(posedge i_clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h0, q);
        chk(q, {24'h0, e});
    endtask
    task unlock(input logic [7:0] ctl);
        // three writes back to back, nothing in between
        wr(OFS_UNLOCK, UNLOCK_KEY1);
        wr(OFS_UNLOCK, UNLOCK_KEY2);
        wr(OFS_CONTROL, ctl);
    endtask
    initial begin
        logic [7:0] a, d;
        logic [13:0] w;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        unlock(8'h06);
        rd(OFS_CONTROL, 8'h04);
        repeat (20) @(posedge i_clk);
        unlock(8'h02);
        rd(OFS_CONTROL, 8'h00);
        unlock(8'h86);
        rd(OFS_CONTROL, 8'h84);
        wr(OFS_UNLOCK, UNLOCK_KEY2);
        wr(OFS_UNLOCK, UNLOCK_KEY1);
        wr(OFS_CONTROL, 8'h06);
        rd(OFS_CONTROL, 8'h04);
        rd(OFS_UNLOCK, 8'h00);
        rd(8'h1c, 8'h00);
        for (int i = 0; i < 3; i++) begin
            a = rnd();
            d = rnd();
            wr(OFS_ADDR_LOW, a);
            wr(OFS_DATA_LOW, d);
            unlock(8'h06);
            model_mem[a] = d;
            rd(OFS_CONTROL, 8'h06);
            wr(OFS_CONTROL, 8'h01);
            rd(OFS_CONTROL, 8'h02);
            rd(OFS_DATA_LOW, d);
            while (busy !== 1'b0) @(posedge i_clk);
            chk({31'h0, done}, 32'h1);
            rd(OFS_STATUS, 8'h01);
            rd(OFS_CONTROL, 8'h00);
            wr(OFS_STATUS, 8'h01);
            rd(OFS_STATUS, 8'h00);
            wr(OFS_DATA_LOW, 8'h00);
            wr(OFS_CONTROL, 8'h01);
            rd(OFS_DATA_LOW, model_mem[a]);
            rd(OFS_DATA_LOW, model_mem[a]);
        end
        a = rnd();
        w = pw({4'hf, a});
        wr(OFS_ADDR_HIGH, 8'hff);
        rd(OFS_ADDR_HIGH, 8'h0f);
        wr(OFS_DATA_HIGH, 8'hff);
        rd(OFS_DATA_HIGH, 8'h3f);
        wr(OFS_ADDR_LOW, a);
        wr(OFS_CONTROL, 8'h81);
        // the fetch slot is settled at the falling edge
        @(negedge i_clk);
        chk({30'h0, prd, stall}, 32'h3);
        chk({20'h0, paddr}, {20'h0, 4'hf, a});
        repeat (4) @(posedge i_clk);
        rd(OFS_DATA_LOW, w[7:0]);
        rd(OFS_DATA_HIGH, {2'h0, w[13:8]});
        for (int k = 0; k < 3; k++) begin
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_ADDR_LOW, 8'h00);
            unlock(8'h06);
            model_mem[0] = ERASED_BYTE;
            rst_src[k] <= 1'b1;
            repeat (3) @(posedge i_clk);
            rst_src[k] <= 1'b0;
            repeat (20) @(posedge i_clk);
            chk({31'h0, busy}, 32'h0);
            rd(OFS_CONTROL, 8'h08);
            wr(OFS_CONTROL, 8'h01);
            rd(OFS_DATA_LOW, model_mem[0]);
        end
        conclude();
    end
endmodule
`default_nettype wire
